// ### design/udw_defs.svh
// Purpose: constants for the up/down wiper host controller
// Assumes: 100 MHz clock
// Notes:   timing figures are plain defaults, not device limits
`ifndef UDW_DEFS_SVH
`define UDW_DEFS_SVH
`define UDW_POS_W        6
`define UDW_POS_MIN      6'h00
`define UDW_POS_MAX      6'h3F
`define UDW_POS_DEFAULT  6'h1F
`define UDW_CLK_NS       10
`define UDW_SETUP_NS     100
`define UDW_HALF_NS      100
`define UDW_CYC(ns)      (((ns) + `UDW_CLK_NS - 1) / `UDW_CLK_NS)
`endif

// ### design/udw_pkg.sv
// Purpose: types for the up/down wiper host controller
// Assumes: nothing
// Notes:   command variants as the controller issues them
package udw_pkg;
    typedef enum logic [2:0] {
        UDW_CMD_INC      = 3'h0,
        UDW_CMD_INC_COMP = 3'h1,
        UDW_CMD_DEC      = 3'h2,
        UDW_CMD_DEC_COMP = 3'h3,
        UDW_CMD_HV_INC1  = 3'h4,
        UDW_CMD_HV_INC2  = 3'h5,
        UDW_CMD_HV_DEC1  = 3'h6,
        UDW_CMD_HV_DEC2  = 3'h7
    } udw_cmd_t;

    typedef struct packed {
        udw_cmd_t   cmd;
        logic [5:0] steps;
    } udw_req_t;

    typedef struct packed {
        logic cs_n;
        logic cs_overdrive_level;
        logic up_dn;
    } udw_pins_t;
endpackage

// ### design/udw_timer.sv
// Purpose: phase timer, pulses done when a loaded count expires
// Assumes: load and count are synchronous
// Notes:   count of zero expires after one cycle
`timescale 1ns/1ps
`default_nettype none
module udw_timer #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output var  logic         done
);
    logic [W-1:0] cnt_r;
    logic         run_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (cnt_r == '0) begin
                run_r <= 1'b0;
            end
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // done must not look at load: the caller builds load from done
    assign done = run_r && (cnt_r == '0);
endmodule
`default_nettype wire

// ### design/udw_host.sv
// Purpose: host that drives the two-wire up/down wiper interface
// Assumes: req is taken while ready is high; pins go to the device
// Notes:   wiper is write-only, so a shadow count is kept here
//
// Behaviour
// - every command starts from select high
// - low selects standard, overdrive selects high-voltage
// - up/down high before select gives increment
// - up/down low before select gives decrement
// - return select high after the park phase that follows the last step
// - compat increment ends with up/down low
// - standard decrement ends with up/down low
// - compat decrement ends with up/down high, or low when it has no steps
// - overdrive commands use same direction rule
`include "udw_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module udw_host #(
    parameter int SETUP_CYC = `UDW_CYC(`UDW_SETUP_NS),
    parameter int HALF_CYC  = `UDW_CYC(`UDW_HALF_NS)
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              dev_por,
    input  wire logic              req_valid,
    input  wire udw_pkg::udw_req_t req,
    output var  logic              req_ready,
    output var  logic              busy,
    output var  udw_pkg::udw_pins_t pins,
    output var  logic [5:0]        wiper_pos
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [5:0] {
        UDW_S_IDLE  = 6'b000001,
        UDW_S_DIR   = 6'b000010,
        UDW_S_SEL   = 6'b000100,
        UDW_S_LOW   = 6'b001000,
        UDW_S_HIGH  = 6'b010000,
        UDW_S_PARK  = 6'b100000
    } udw_state_t;

    udw_state_t         st_r, st_nxt;
    udw_pkg::udw_req_t  req_r;
    logic [5:0]         left_r;
    logic [5:0]         pos_r, pos_nxt;
    logic               cs_n_r, ovd_r, ud_r;
    logic               ud_nxt, tload;
    logic               tdone;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire cmd_inc   = !req_r.cmd[1];
    wire cmd_hv    = req_r.cmd[2];
    // end level of up/down: high only for compat decrement / hv 1-inc / hv dec2
    wire end_high  = (req_r.cmd == udw_pkg::UDW_CMD_DEC_COMP) ||
                     (req_r.cmd == udw_pkg::UDW_CMD_HV_INC1)  ||
                     (req_r.cmd == udw_pkg::UDW_CMD_HV_DEC2);
    // a stepless decrement parks low: a rise there would be a stray step
    wire park_high = end_high && !(!cmd_inc && req_r.steps == 6'h00);
    wire take      = (st_r == UDW_S_IDLE) && req_valid && req_ready;
    wire step_edge = (st_r == UDW_S_LOW) && tdone;
    wire at_max    = (pos_r == `UDW_POS_MAX);
    wire at_min    = (pos_r == `UDW_POS_MIN);

    udw_timer #(.W(8)) u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .load  (tload),
        .count (8'(HALF_CYC > SETUP_CYC ? HALF_CYC - 1 : SETUP_CYC - 1)),
        .done  (tdone)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        ud_nxt = ud_r;
        tload  = 1'b0;
        case (st_r)
            UDW_S_IDLE: begin
                if (take) begin
                    st_nxt = UDW_S_DIR;
                    ud_nxt = !req.cmd[1];
                    tload  = 1'b1;
                end
            end
            UDW_S_DIR: begin
                if (tdone) begin
                    st_nxt = UDW_S_SEL;
                    tload  = 1'b1;
                end
            end
            UDW_S_SEL: begin
                if (tdone) begin
                    tload = 1'b1;
                    if (left_r == 6'h00) begin
                        st_nxt = UDW_S_PARK;
                        ud_nxt = park_high;
                    end else begin
                        st_nxt = UDW_S_LOW;
                        ud_nxt = 1'b0;
                    end
                end
            end
            UDW_S_LOW: begin
                if (tdone) begin
                    st_nxt = UDW_S_HIGH;
                    ud_nxt = 1'b1;
                    tload  = 1'b1;
                end
            end
            UDW_S_HIGH: begin
                if (tdone) begin
                    st_nxt = UDW_S_SEL;
                    tload  = 1'b1;
                end
            end
            UDW_S_PARK: begin
                if (tdone) begin
                    st_nxt = UDW_S_IDLE;
                end
            end
            default: begin
                st_nxt = UDW_S_IDLE;
            end
        endcase
    end

    // shadow tracks the device: saturate, never wrap
    always_comb begin
        pos_nxt = pos_r;
        if (dev_por) begin
            pos_nxt = `UDW_POS_DEFAULT;
        end else if (step_edge && cmd_inc && !at_max) begin
            pos_nxt = pos_r + 6'h01;
        end else if (step_edge && !cmd_inc && !at_min) begin
            pos_nxt = pos_r - 6'h01;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= UDW_S_IDLE;
            req_r  <= '0;
            left_r <= 6'h00;
            pos_r  <= `UDW_POS_DEFAULT;
            ud_r   <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            ud_r  <= ud_nxt;
            pos_r <= pos_nxt;
            if (take) begin
                req_r  <= req;
                left_r <= req.steps;
            end else if (step_edge) begin
                left_r <= left_r - 6'h01;
            end
        end
    end

    // select pins are registered from the next state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_r <= 1'b1;
            ovd_r  <= 1'b0;
        end else begin
            cs_n_r <= (st_nxt == UDW_S_IDLE) || (st_nxt == UDW_S_DIR) ||
                      (st_r == UDW_S_PARK && tdone);
            ovd_r  <= cmd_hv && (st_nxt != UDW_S_IDLE) &&
                      (st_nxt != UDW_S_DIR);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            busy      <= 1'b0;
        end else begin
            req_ready <= (st_nxt == UDW_S_IDLE);
            busy      <= (st_nxt != UDW_S_IDLE);
        end
    end

    // cs_n stays low during overdrive; ovd qualifies it as overdrive level
    assign pins.cs_n               = cs_n_r;
    assign pins.cs_overdrive_level = ovd_r;
    assign pins.up_dn              = ud_r;
    assign wiper_pos               = pos_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_idle_select: assert property (@(posedge clock) disable iff (!rst_n)
        (st_r == UDW_S_IDLE) |-> cs_n_r && !ovd_r)
        else $error("select active while idle");
    chk_pos_max: assert property (@(posedge clock) disable iff (!rst_n)
        at_max && !dev_por && cmd_inc |=> at_max)
        else $error("shadow passed maximum");
    chk_pos_min: assert property (@(posedge clock) disable iff (!rst_n)
        at_min && !dev_por && !cmd_inc |=> at_min)
        else $error("shadow passed minimum");
    chk_por_load: assert property (@(posedge clock) disable iff (!rst_n)
        dev_por |=> pos_r == `UDW_POS_DEFAULT)
        else $error("default not reloaded");
    chk_dir_setup: assert property (@(posedge clock) disable iff (!rst_n)
        take |=> ud_r == !req_r.cmd[1])
        else $error("direction level wrong");
    chk_park_end: assert property (@(posedge clock) disable iff (!rst_n)
        (st_r == UDW_S_PARK) |-> ud_r == park_high)
        else $error("end level wrong");
    chk_step_count: assert property (@(posedge clock) disable iff (!rst_n)
        step_edge |=> left_r == $past(left_r) - 6'h01)
        else $error("step count wrong");
    chk_hv_level: assert property (@(posedge clock) disable iff (!rst_n)
        ovd_r |-> cmd_hv)
        else $error("overdrive on standard command");
    cov_inc: cover property (@(posedge clock) step_edge && cmd_inc);
    cov_dec: cover property (@(posedge clock) step_edge && !cmd_inc);
    cov_hv: cover property (@(posedge clock) ovd_r);
    cov_sat: cover property (@(posedge clock) step_edge && at_max);
endmodule
`default_nettype wire

// ### sim/udw_dev_model.sv
// Purpose: behavioural up/down wiper device at the far side
// Assumes: select stays low while overdrive is high
// Notes: event driven; pos is a bench view only, no readback
`timescale 1ns/1ps
`default_nettype none
module udw_dev_model (
    input  wire logic       por,
    input  wire logic       cs_n,
    input  wire logic       hv,
    input  wire logic       up_dn,
    output var  logic [5:0] pos,
    output var  logic       end_lvl,
    output var  logic       was_hv
);
    logic dir;
    initial begin
        pos = 6'h1F;
        dir = 1'b0;
        end_lvl = 1'b0;
        was_hv = 1'b0;
    end
    // direction fixed at select fall
    always @(negedge cs_n) dir = up_dn;
    // overdrive may land in the same step as the select fall
    always @(negedge cs_n or posedge hv) was_hv = hv;
    // one writer for pos; power-up reload
    // edges with select high do nothing
    always @(posedge por or posedge up_dn) begin
        if (por) pos = 6'h1F;
        else if (!cs_n && dir && pos != 6'h3F) pos = pos + 6'h01;
        else if (!cs_n && !dir && pos != 6'h00) pos = pos - 6'h01;
    end
    always @(posedge cs_n) end_lvl = up_dn;
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench for the wiper host controller
// Assumes: short phase counts keep the run brief
// Notes:   expected position is saturating arithmetic on the command
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic               clock, rst_n, dev_por, req_valid;
    logic               req_ready, busy, end_lvl, was_hv;
    udw_pkg::udw_req_t  req;
    udw_pkg::udw_pins_t pins;
    logic [5:0]         wiper_pos, dev_pos, exp_pos;
    integer             seed, bad_count, n_compared, i, n;
    udw_host #(.SETUP_CYC(2), .HALF_CYC(2)) DUT (
        .clock(clock), .rst_n(rst_n), .dev_por(dev_por),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .busy(busy), .pins(pins), .wiper_pos(wiper_pos)
    );
    udw_dev_model u_dev (
        .por(dev_por), .cs_n(pins.cs_n), .hv(pins.cs_overdrive_level),
        .up_dn(pins.up_dn), .pos(dev_pos), .end_lvl(end_lvl),
        .was_hv(was_hv)
    );
    initial clock = 1'b0;
    always #5 clock = ~clock;
    task check(input string what, input logic [5:0] seen,
               input logic [5:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [5:0] next_pos(logic [5:0] p, logic [2:0] c,
                                            logic [5:0] s);
        int q;
        q = c[1] ? int'(p) - int'(s) : int'(p) + int'(s);
        if (q < 0) q = 0;
        if (q > 63) q = 63;
        return q[5:0];
    endfunction
    function automatic logic exp_end(logic [2:0] c, logic [5:0] s);
        // a stepless decrement cannot park high without a stray step
        return (c == 3'h4) || ((c == 3'h3 || c == 3'h7) && s != 6'h00);
    endfunction
    // signals are read live here, never copied into an argument
    task wait_while(input bit on_busy);
        int k;
        k = 0;
        while ((on_busy ? busy === 1'b1 : req_ready === 1'b0) &&
               k < 2000) begin
            @(posedge clock);
            #1;
            k = k + 1;
        end
        if (k == 2000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    endtask
    task run(input logic [2:0] c, input logic [5:0] s);
        exp_pos = next_pos(exp_pos, c, s);
        wait_while(1'b0);
        req_valid = 1'b1;
        req.cmd = udw_pkg::udw_cmd_t'(c);
        req.steps = s;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        @(posedge clock);
        #1;
        wait_while(1'b1);
        check("dev_pos", dev_pos, exp_pos);
        check("wiper_pos", wiper_pos, exp_pos);
        check("end_lvl", {5'h00, end_lvl},
              {5'h00, exp_end(c, s)});
        check("overdrive", {5'h00, was_hv}, {5'h00, c[2]});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hA43A3650;
        bad_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        dev_por = 1'b0;
        req_valid = 1'b0;
        req = '0;
        exp_pos = 6'h1F;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        dev_por = 1'b1;
        @(posedge clock);
        #1;
        dev_por = 1'b0;
        check("wiper_pos", wiper_pos, 6'h1F);
        check("dev_pos", dev_pos, 6'h1F);
        run(3'h0, 6'h3F);
        run(3'h5, 6'h02);
        run(3'h2, 6'h3F);
        run(3'h6, 6'h01);
        for (i = 0; i < 8; i = i + 1) run(i[2:0], 6'h05);
        run(3'h1, 6'h00);
        run(3'h3, 6'h00);
        run(3'h7, 6'h00);
        for (i = 0; i < 20; i = i + 1) begin
            n = $random(seed);
            run(n[2:0], n[8:3]);
        end
        // brown-out recovery while idle
        dev_por = 1'b1;
        @(posedge clock);
        #1;
        dev_por = 1'b0;
        exp_pos = 6'h1F;
        @(posedge clock);
        #1;
        check("wiper_pos", wiper_pos, 6'h1F);
        check("dev_pos", dev_pos, 6'h1F);
        run(3'h3, 6'h04);
        give_verdict;
    end
endmodule
`default_nettype wire
